// *** rtl/mlg_defs.vh ***
/*
 Constants for the motor lock and clock loss guard.
 Assumes inclusion by bare name from design files under rtl/.
*/
`ifndef MLG_DEFS_VH
`define MLG_DEFS_VH
`define MLG_LOCK_COUNT 7'h60
`define MLG_CLKLOSS_COUNT 7'h03
`define MLG_CNT_W 7
`define MLG_TB_RES_OHM 18'h30d40
`define MLG_TSD_ON_DEGC 9'h0af
`define MLG_TSD_HYST_DEGC 9'h019
`define MLG_TEMP_W 9
`define MLG_SYNC_W 4
`endif

// *** rtl/mlg_timeout.v ***
/*
 Edge-absence timeout counter stepped by a shared time-base tick.
 Assumes all inputs are already synchronised to clk.
*/
`timescale 1ns/1ns
`include "mlg_defs.vh"
module mlg_timeout #(
  parameter [`MLG_CNT_W-1:0] LIMIT = `MLG_LOCK_COUNT
) (
  input wire clk, // System clock
  input wire nrst, // Synchronous reset, active low
  input wire ce, // Clock enable
  input wire clear_latch, // Standby reset of the latch
  input wire tick, // One protection time base period
  input wire edge_seen, // Transition of the watched signal
  output reg timeout // Latched timeout
);
  localparam [`MLG_CNT_W-1:0] ONE = {{(`MLG_CNT_W-1){1'b0}}, 1'b1};
  localparam [`MLG_CNT_W-1:0] LAST = LIMIT - ONE;
  reg [`MLG_CNT_W-1:0] count;
  always @(posedge clk) begin
    if (!nrst) begin
      count <= {`MLG_CNT_W{1'b0}};
      timeout <= 1'b0;
    end else if (ce) begin
      if (edge_seen || clear_latch) begin
        count <= {`MLG_CNT_W{1'b0}};
      end else if (tick && count != LIMIT) begin
        count <= count + ONE;
      end
      if (clear_latch) begin
        timeout <= 1'b0;
      end else if (!edge_seen && tick && count == LAST) begin
        timeout <= 1'b1;
      end
    end
  end
endmodule

// *** rtl/mlg_guard.v ***
/*
 Motor lock and clock loss guard: timeouts, latches and thermal cutoff.
 Assumes pins arrive asynchronous; time base edges come from a capacitor oscillator.
*/
// What this block does
// - Flag torque reduction after 96 time-base periods without feedback edge.
// - Lock flag stays until power-up reset or standby input.
// - Open motor outputs after 3 time-base periods without reference clock edge.
// - Clock-loss open stays until power-up reset or standby input.
// - Detection may be one time-base period early or late.
// - Both counters share one time base, period C times 200k.
// - Over-temperature opens outputs; resume after 25 degree fall.
`timescale 1ns/1ns
`include "mlg_defs.vh"
module mlg_guard #(
  parameter [`MLG_CNT_W-1:0] LOCK_COUNT = `MLG_LOCK_COUNT,
  parameter [`MLG_CNT_W-1:0] CLKLOSS_COUNT = `MLG_CLKLOSS_COUNT
) (
  input wire clk, // System clock, 100 MHz
  input wire nrst, // Synchronous reset, active low
  input wire ce, // Clock enable, freezes all state
  input wire protect_timebase, // Time base pin, period C x 200k s
  input wire speed_feedback_pulse, // Speed feedback pin
  input wire ref_clock, // Reference speed clock pin
  input wire standby, // Standby pin, high resets latches
  input wire thermal_cutoff, // Over-temperature comparator at 175 C
  input wire thermal_release, // Cooled by hysteresis, below 150 C
  output reg torque_reduce_flag, // Motor lock indication
  output reg outputs_open, // All motor outputs undriven
  output reg clock_lost, // Reference clock loss latched
  output reg thermal_open // Thermal cutoff active
);

  ////////////////////////////////////////////////////////////////
  // Thermal states, one-hot
  localparam [1:0] TH_RUN = 2'h1;
  localparam [1:0] TH_HOT = 2'h2;

  ////////////////////////////////////////////////////////////////
  // Level change of a synchronised pin against its last sample
  function edge_any;
    input now_level;
    input last_level;
    begin
      edge_any = now_level ^ last_level;
    end
  endfunction

  // Rising edge of a synchronised pin
  function edge_rise;
    input now_level;
    input last_level;
    begin
      edge_rise = now_level & ~last_level;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Two flip-flops per pin before any logic reads it
  // Standby and thermal levels pass the same two stages
  reg tb_s1;
  reg tb_s2;
  reg fg_s1;
  reg fg_s2;
  reg rc_s1;
  reg rc_s2;
  reg sb_s1;
  reg sb_s2;
  reg hot_s1;
  reg hot_s2;
  reg cool_s1;
  reg cool_s2;

  always @(posedge clk) begin
    if (!nrst) begin
      tb_s1 <= 1'b0;
      tb_s2 <= 1'b0;
      fg_s1 <= 1'b0;
      fg_s2 <= 1'b0;
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      sb_s1 <= 1'b0;
      sb_s2 <= 1'b0;
      hot_s1 <= 1'b0;
      hot_s2 <= 1'b0;
      cool_s1 <= 1'b0;
      cool_s2 <= 1'b0;
    end else if (ce) begin
      tb_s1 <= protect_timebase;
      tb_s2 <= tb_s1;
      fg_s1 <= speed_feedback_pulse;
      fg_s2 <= fg_s1;
      rc_s1 <= ref_clock;
      rc_s2 <= rc_s1;
      sb_s1 <= standby;
      sb_s2 <= sb_s1;
      hot_s1 <= thermal_cutoff;
      hot_s2 <= hot_s1;
      cool_s1 <= thermal_release;
      cool_s2 <= cool_s1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Last synchronised level of each watched pin
  // A pin high at reset release gives one extra tick, inside the one-count slack
  reg tb_d;
  reg fg_d;
  reg rc_d;

  always @(posedge clk) begin
    if (!nrst) begin
      tb_d <= 1'b0;
      fg_d <= 1'b0;
      rc_d <= 1'b0;
    end else if (ce) begin
      tb_d <= tb_s2;
      fg_d <= fg_s2;
      rc_d <= rc_s2;
    end
  end

  wire tick;
  wire fg_edge;
  wire rc_edge;
  wire clear_latches;

  // One tick per time-base period, shared by both counters
  assign tick = edge_rise(tb_s2, tb_d);
  assign fg_edge = edge_any(fg_s2, fg_d);
  assign rc_edge = edge_any(rc_s2, rc_d);
  // Standby holds both counters and latches cleared
  assign clear_latches = sb_s2;

  ////////////////////////////////////////////////////////////////
  // Lock and clock-loss timeouts
  wire lock_hit;
  wire loss_hit;

  // A stopped motor raises the torque-reduce flag
  mlg_timeout #(
    .LIMIT(LOCK_COUNT)
  ) u_lock (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .clear_latch(clear_latches),
    .tick(tick),
    .edge_seen(fg_edge),
    .timeout(lock_hit)
  );

  // A missing reference clock opens the outputs
  mlg_timeout #(
    .LIMIT(CLKLOSS_COUNT)
  ) u_loss (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .clear_latch(clear_latches),
    .tick(tick),
    .edge_seen(rc_edge),
    .timeout(loss_hit)
  );

  ////////////////////////////////////////////////////////////////
  // Thermal cutoff with hysteresis; cutoff wins over release
  // Outputs stay open until release is seen with cutoff low
  reg [1:0] th_state;
  reg [1:0] next_th_state;

  always @* begin
    next_th_state = th_state;
    case (th_state)
      TH_RUN: begin
        if (hot_s2) begin
          next_th_state = TH_HOT;
        end
      end
      TH_HOT: begin
        if (cool_s2 && !hot_s2) begin
          next_th_state = TH_RUN;
        end
      end
      // Unreachable codes fall back to the safe, open state
      default: begin
        next_th_state = TH_HOT;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      th_state <= TH_RUN;
    end else if (ce) begin
      th_state <= next_th_state;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Registered indications and the output-open request
  // outputs_open is clock_lost or thermal_open in the same cycle
  wire next_thermal_open;

  assign next_thermal_open = (next_th_state != TH_RUN);

  always @(posedge clk) begin
    if (!nrst) begin
      torque_reduce_flag <= 1'b0;
      clock_lost <= 1'b0;
      thermal_open <= 1'b0;
      outputs_open <= 1'b0;
    end else if (ce) begin
      torque_reduce_flag <= lock_hit;
      clock_lost <= loss_hit;
      thermal_open <= next_thermal_open;
      outputs_open <= loss_hit | next_thermal_open;
    end
  end

endmodule

// *** verification/mlg_chk.sv ***
/*
 Concurrent assertions on the guard's ports.
 Assumes ce stays high while any latch or standby is active; bound into mlg_guard.
*/
`timescale 1ns/1ns
module mlg_chk (
  input wire clk, // System clock
  input wire nrst, // Synchronous reset, active low
  input wire standby, // Standby pin
  input wire torque_reduce_flag, // Lock indication
  input wire clock_lost, // Clock loss latch
  input wire outputs_open, // Outputs undriven
  input wire thermal_open // Thermal cutoff state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_lk;
    (!standby [*4]) ##0 torque_reduce_flag |=> torque_reduce_flag;
  endproperty
  a_lk: assert property (p_lk) else $error("lock flag dropped");
  property p_cl;
    (!standby [*4]) ##0 clock_lost |=> clock_lost;
  endproperty
  a_cl: assert property (p_cl) else $error("clock loss dropped");
  property p_sb;
    standby [*5] |-> !torque_reduce_flag && !clock_lost;
  endproperty
  a_sb: assert property (p_sb) else $error("standby did not clear latches");
  property p_oo;
    clock_lost |-> outputs_open;
  endproperty
  a_oo: assert property (p_oo) else $error("clock loss without open outputs");
  property p_th;
    thermal_open |-> outputs_open;
  endproperty
  a_th: assert property (p_th) else $error("thermal cutoff without open outputs");
  property p_oc;
    outputs_open |-> clock_lost || thermal_open;
  endproperty
  a_oc: assert property (p_oc) else $error("outputs open without cause");
endmodule
bind mlg_guard mlg_chk i_chk (.*);

// *** verification/mlg_motor.sv ***
/* Motor and clock stand-in. */
`timescale 1ns/1ns
module mlg_motor (input wire clk, input wire [1:0] run, output reg [2:0] q = 3'h0);
  reg [2:0] ph = 3'h0;
  always @(negedge clk) ph <= ph + 3'h1;
  always @(negedge clk) q <= q ^ {&ph[1:0], run[1] & &ph, run[0] & ph[0]};
endmodule

// *** verification/testbench.sv ***
/* Guard bench, lock count 8. */
`timescale 1ns/1ns
module testbench;
  reg clk = 0, nrst = 0, standby = 0, thermal_cutoff = 0, thermal_release = 0, ce = 1;
  reg [1:0] run = 2'h3;
  wire protect_timebase, speed_feedback_pulse, ref_clock, torque_reduce_flag, outputs_open;
  wire clock_lost, thermal_open;
  wire [3:0] st = {torque_reduce_flag, clock_lost, outputs_open, thermal_open};
  int num_errors = 0, checks_done = 0;
  always #5 clk = ~clk;
  mlg_motor i_mot (.clk(clk), .run(run),
    .q({protect_timebase, speed_feedback_pulse, ref_clock}));
  mlg_guard #(.LOCK_COUNT(7'h08)) i_dut (.*);
  task w(input int n, logic [4:0] d, logic [3:0] e);
    {run, standby, thermal_cutoff, thermal_release} = d;
    repeat (n) @(negedge clk);
    checks_done++;
    if (st !== e) $display("ERROR st exp %h got %h", e, st);
    num_errors += (st !== e);
  endtask
  task print_verdict(input int extra);
    num_errors += extra;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task t_loss;
    w(200, 5'h18, 4'h0);
    w(4, 5'h00, 4'h0);
    w(36, 5'h00, 4'h6);
    w(48, 5'h00, 4'he);
    w(99, 5'h18, 4'he);
    w(8, 5'h1c, 4'h0);
    $display("loss done");
  endtask
  task t_hot;
    w(10, 5'h1a, 4'h3);
    w(20, 5'h18, 4'h3);
    w(10, 5'h19, 4'h0);
    $display("hot done");
  endtask
  task t_hold;
    ce = 0;
    w(120, 5'h00, 4'h0);
    ce = 1;
    w(8, 5'h18, 4'h0);
    $display("hold done");
  endtask
  initial begin
    w(16, 5'h18, 4'h0);
    nrst = 1;
    t_loss;
    t_hot;
    t_hold;
    print_verdict(0);
  end
  initial #20000 print_verdict(1);
endmodule
